/* File: hdl/zrdf_defines.vh */
// constants for the zero reading detect filter
`ifndef ZRDF_DEFINES_VH
`define ZRDF_DEFINES_VH
`define ZRDF_CFG_ADDR 8'hDB
`define ZRDF_STAT_ADDR 8'hDC
`define ZRDF_WEIGHT_MSB 3
`define ZRDF_ZERO_FLAG_BIT 3
`define ZRDF_CFG_RESET 8'h00
`define ZRDF_CNT_LIMIT 5'h0F
`define ZRDF_CNT_ZERO 5'h00
`define ZRDF_CNT_ONE 5'h01
`define ZRDF_CH_ZERO 16'h0000
`endif

/* File: hdl/zrdf_zero_reading_detect_filter.v */
// zero reading detect filter: weighted zero counter, sticky alarm, register slice
//
// Overview of operation
// (R1) Bits 3:0 of the configuration register hold the zero hit increment weight.
// (R2) The zero alarm flag is set when the internal counter reaches 15.
// (R3) A measurement cycle with any of the four channels reading zero adds the weight.
// (R4) A measurement cycle with no channel reading zero takes one off the counter.
// (R5) Software should use the weight only when both automatic offset fixes are off.
// (R6) The flag reads in status bit 3, interrupts when enabled, and clears on a written one.
// (R7) A weight of zero never raises the flag or its interrupt.
// (R8) The counter floors at zero and saturates at the limit instead of wrapping.
//
// channel results and the measurement strobe come from logic on this clock,
// so no input passes a synchroniser here
`timescale 1ns/1ps
`default_nettype none
`include "zrdf_defines.vh"

module zrdf_zero_reading_detect_filter #(
    parameter CH_W = 16
) (
    input wire clk_i,
    input wire rstn_i,
    // register access port, one byte per access
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] cfg_rdata_o,
    output reg [7:0] stat_rdata_o,
    // measurement results, valid on meas_done_i pulse
    input wire meas_done_i,
    input wire [CH_W-1:0] ch0_data_i,
    input wire [CH_W-1:0] ch1_data_i,
    input wire [CH_W-1:0] ch2_data_i,
    input wire [CH_W-1:0] ch3_data_i,
    input wire calibration_irq_enable_i,
    output wire zero_alarm_flag_o,
    output wire zero_irq_o
);

////////////////////////////////////////////////////////////////////////////////
// local sizes

localparam NUM_CH = 4;
localparam CNT_W = 5;
localparam WT_W = `ZRDF_WEIGHT_MSB + 1;
localparam BUS_W = NUM_CH * CH_W;

////////////////////////////////////////////////////////////////////////////////
// declarations

wire [BUS_W-1:0] ch_bus;
wire [NUM_CH-1:0] ch_zero;
wire any_zero;
wire cfg_sel;
wire stat_sel;
wire cfg_wr;
wire flag_clr;
wire weight_on;
wire [CNT_W-1:0] weight_ext;
wire [CNT_W-1:0] sum;
wire sum_hits_limit;
wire cnt_at_floor;
wire flag_set;

reg [WT_W-1:0] weight_ff;
reg [WT_W-1:0] nxt_weight;
reg [CNT_W-1:0] cnt_ff;
reg [CNT_W-1:0] nxt_cnt;
reg flag_ff;
reg nxt_flag;
reg [7:0] nxt_cfg_rdata;
reg [7:0] nxt_stat_rdata;

////////////////////////////////////////////////////////////////////////////////
// per channel zero compare

assign ch_bus = {ch3_data_i, ch2_data_i, ch1_data_i, ch0_data_i};

genvar gi;
generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_ch_zero
        assign ch_zero[gi] = (ch_bus[gi*CH_W +: CH_W] == {CH_W{1'b0}}); // see (R3)
    end
endgenerate

// one zero on any channel is enough to count the cycle as a zero cycle
assign any_zero = |ch_zero; // see (R3) see (R4)

////////////////////////////////////////////////////////////////////////////////
// register decode

assign cfg_sel = (reg_addr_i == `ZRDF_CFG_ADDR);
assign stat_sel = (reg_addr_i == `ZRDF_STAT_ADDR);
assign cfg_wr = reg_wr_i && cfg_sel; // see (R1)
assign flag_clr = reg_wr_i && stat_sel && reg_wdata_i[`ZRDF_ZERO_FLAG_BIT]; // see (R6)

////////////////////////////////////////////////////////////////////////////////
// counter arithmetic

assign weight_on = (weight_ff != {WT_W{1'b0}}); // see (R7)
assign weight_ext = {{(CNT_W-WT_W){1'b0}}, weight_ff};
// five bits hold 15 + 15, so the sum itself never wraps
assign sum = cnt_ff + weight_ext;
assign sum_hits_limit = (sum >= `ZRDF_CNT_LIMIT);
assign cnt_at_floor = (cnt_ff == `ZRDF_CNT_ZERO);

// set on every zero measurement with a nonzero weight whose sum is at or over the limit, even with the counter already saturated
assign flag_set = meas_done_i && any_zero && sum_hits_limit && weight_on; // see (R2) see (R7)

////////////////////////////////////////////////////////////////////////////////
// next weight

always @*
begin
    nxt_weight = weight_ff;
    if (cfg_wr)
    begin
        nxt_weight = reg_wdata_i[`ZRDF_WEIGHT_MSB:0]; // see (R1)
    end
end

////////////////////////////////////////////////////////////////////////////////
// next counter

always @*
begin
    nxt_cnt = cnt_ff;
    if (meas_done_i)
    begin
        if (any_zero)
        begin
            // saturate so a large weight cannot carry past the limit
            if (sum_hits_limit)
            begin
                nxt_cnt = `ZRDF_CNT_LIMIT; // see (R3) see (R8)
            end
            else
            begin
                nxt_cnt = sum; // see (R3)
            end
        end
        else
        begin
            if (!cnt_at_floor)
            begin
                nxt_cnt = cnt_ff - `ZRDF_CNT_ONE; // see (R4) see (R8)
            end
            else
            begin
                nxt_cnt = `ZRDF_CNT_ZERO; // see (R8)
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// next flag

always @*
begin
    nxt_flag = flag_ff;
    if (flag_clr)
    begin
        nxt_flag = 1'b0; // see (R6)
    end
    // set beats a clear in the same cycle
    if (flag_set)
    begin
        nxt_flag = 1'b1; // see (R2)
    end
end

////////////////////////////////////////////////////////////////////////////////
// next read back values

always @*
begin
    nxt_cfg_rdata = `ZRDF_CFG_RESET;
    nxt_cfg_rdata[`ZRDF_WEIGHT_MSB:0] = nxt_weight; // see (R1)
    nxt_stat_rdata = 8'h00;
    nxt_stat_rdata[`ZRDF_ZERO_FLAG_BIT] = nxt_flag; // see (R6)
end

////////////////////////////////////////////////////////////////////////////////
// state registers

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        weight_ff <= {WT_W{1'b0}};
    end
    else
    begin
        weight_ff <= nxt_weight;
    end
end

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        cnt_ff <= `ZRDF_CNT_ZERO;
    end
    else
    begin
        cnt_ff <= nxt_cnt;
    end
end

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        flag_ff <= 1'b0;
    end
    else
    begin
        flag_ff <= nxt_flag;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read back registers

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        cfg_rdata_o <= `ZRDF_CFG_RESET;
    end
    else
    begin
        cfg_rdata_o <= nxt_cfg_rdata;
    end
end

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        stat_rdata_o <= 8'h00;
    end
    else
    begin
        stat_rdata_o <= nxt_stat_rdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign zero_alarm_flag_o = flag_ff;
// the irq is also gated by weight so writing zero silences it at once
assign zero_irq_o = flag_ff && calibration_irq_enable_i && weight_on; // see (R6) see (R7)

endmodule // zrdf_zero_reading_detect_filter
`default_nettype wire

/* File: tb/zrdf_chk.sv */
// port-level assertions for the zero reading detect filter
`timescale 1ns/1ps
`default_nettype none
module zrdf_chk #(parameter CH_W = 16) (
    input wire clk_i, rstn_i, reg_wr_i, meas_done_i, calibration_irq_enable_i,
    input wire zero_alarm_flag_o, zero_irq_o,
    input wire [7:0] reg_addr_i, reg_wdata_i, cfg_rdata_o, stat_rdata_o,
    input wire [CH_W-1:0] ch0_data_i, ch1_data_i, ch2_data_i, ch3_data_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire any_zero = ch0_data_i == {CH_W{1'b0}} || ch1_data_i == {CH_W{1'b0}}
        || ch2_data_i == {CH_W{1'b0}} || ch3_data_i == {CH_W{1'b0}};
    wire clr = reg_wr_i && reg_addr_i == 8'hDC && reg_wdata_i[3];
    cfg_write_a: assert property (reg_wr_i && reg_addr_i == 8'hDB |=>
        cfg_rdata_o == {4'h0, $past(reg_wdata_i[3:0])}) else $error("weight not stored");
    cfg_keep_a: assert property (!(reg_wr_i && reg_addr_i == 8'hDB)
        |=> $stable(cfg_rdata_o)) else $error("weight changed");
    flag_set_a: assert property (meas_done_i && any_zero && cfg_rdata_o[3:0] == 4'hF
        |=> zero_alarm_flag_o) else $error("flag not raised");
    stat_bit_a: assert property (stat_rdata_o == {4'h0, zero_alarm_flag_o, 3'h0})
        else $error("status mismatch");
    irq_gate_a: assert property (zero_irq_o == (zero_alarm_flag_o
        && calibration_irq_enable_i && cfg_rdata_o[3:0] != 4'h0)) else $error("irq mismatch");
    flag_keep_a: assert property (zero_alarm_flag_o && !clr |=> zero_alarm_flag_o)
        else $error("flag dropped");
    zero_weight_a: assert property (!zero_alarm_flag_o && cfg_rdata_o[3:0] == 4'h0
        |=> !zero_alarm_flag_o) else $error("flag with weight zero");
endmodule // zrdf_chk
bind zrdf_zero_reading_detect_filter zrdf_chk #(.CH_W(CH_W)) chk_u (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .reg_wr_i(reg_wr_i),
    .meas_done_i(meas_done_i),
    .calibration_irq_enable_i(calibration_irq_enable_i),
    .zero_alarm_flag_o(zero_alarm_flag_o),
    .zero_irq_o(zero_irq_o),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o),
    .stat_rdata_o(stat_rdata_o),
    .ch0_data_i(ch0_data_i),
    .ch1_data_i(ch1_data_i),
    .ch2_data_i(ch2_data_i),
    .ch3_data_i(ch3_data_i)
);
`default_nettype wire

/* File: tb/zrdf_host.sv */
// host model: register writes and measurement cycles
`timescale 1ns/1ps
`default_nettype none
module zrdf_host (
    input wire clk_i,
    output logic [7:0] a_o, d_o,
    output logic wr_o, md_o,
    output logic [15:0] ch_o
);
    // no automatic offset fix here, offsets stay with software
    initial {a_o, d_o, wr_o, md_o, ch_o} = 34'h1;
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk_i) {a_o, d_o, wr_o} = {a, d, 1'b1};
        @(negedge clk_i) wr_o = 0;
    endtask
    task ms(input z, input int n);
        repeat (n)
        begin
            @(negedge clk_i) {md_o, ch_o} = {1'b1, z ? 16'h0000 : 16'h0001};
            @(negedge clk_i) {md_o, ch_o} = {1'b0, ~ch_o}; // released: never a stale value
        end
    endtask
endmodule // zrdf_host
`default_nettype wire

/* File: tb/tb_zero_reading_detect_filter.sv */
// testbench for the zero reading detect filter
`timescale 1ns/1ps
`default_nettype none
module tb_zero_reading_detect_filter;
    wire [7:0] reg_addr_i, reg_wdata_i, cfg_rdata_o, stat_rdata_o;
    wire reg_wr_i, meas_done_i, zero_alarm_flag_o, zero_irq_o;
    wire [15:0] ch3_data_i;
    logic clk_i = 0, rstn_i = 0, calibration_irq_enable_i = 1;
    logic [15:0] ch0_data_i = 16'h00A5, ch1_data_i = 16'h00A5, ch2_data_i = 16'h00A5;
    int err_total = 0, tests_run = 0;
    always #4 clk_i = ~clk_i;
    zrdf_zero_reading_detect_filter dut_u (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i),
        .cfg_rdata_o(cfg_rdata_o),
        .stat_rdata_o(stat_rdata_o),
        .meas_done_i(meas_done_i),
        .ch0_data_i(ch0_data_i),
        .ch1_data_i(ch1_data_i),
        .ch2_data_i(ch2_data_i),
        .ch3_data_i(ch3_data_i),
        .calibration_irq_enable_i(calibration_irq_enable_i),
        .zero_alarm_flag_o(zero_alarm_flag_o),
        .zero_irq_o(zero_irq_o)
    );
    zrdf_host pm_u (.clk_i(clk_i), .a_o(reg_addr_i), .d_o(reg_wdata_i), .wr_o(reg_wr_i),
        .md_o(meas_done_i), .ch_o(ch3_data_i));
    task chk(input string n, input [7:0] s, input [7:0] e);
        tests_run++;
        if (s !== e) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // the whole sequence needs about a hundred cycles; this allows about twenty-five times that
    initial begin #20000; err_total++; wrap_up; end
    initial
    begin
        repeat (3) @(negedge clk_i);
        rstn_i = 1;
        chk("cfg", cfg_rdata_o, 8'h00);
        chk("irq", zero_irq_o, 8'h00);
        pm_u.wr(8'hDB, 8'hF0);
        pm_u.ms(1, 4);
        chk("flag", zero_alarm_flag_o, 8'h00);
        pm_u.wr(8'hDB, 8'hA5);
        chk("cfg", cfg_rdata_o, 8'h05);
        pm_u.ms(1, 2);
        chk("flag", zero_alarm_flag_o, 8'h00);
        pm_u.ms(1, 1);
        chk("stat", stat_rdata_o, 8'h08);
        chk("irq", zero_irq_o, 8'h01);
        calibration_irq_enable_i = 0;
        @(negedge clk_i);
        chk("irq", zero_irq_o, 8'h00);
        calibration_irq_enable_i = 1;
        pm_u.wr(8'hDC, 8'h00);
        chk("flag", zero_alarm_flag_o, 8'h01);
        pm_u.ms(0, 1);
        pm_u.wr(8'hDC, 8'h08);
        @(negedge clk_i);
        chk("flag", zero_alarm_flag_o, 8'h00);
        $display("weighted raise done");
        pm_u.ms(0, 16);
        pm_u.wr(8'hDB, 8'h07);
        pm_u.ms(1, 2);
        chk("flag", zero_alarm_flag_o, 8'h00);
        pm_u.ms(1, 1);
        chk("flag", zero_alarm_flag_o, 8'h01);
        pm_u.ms(0, 8);
        chk("flag", zero_alarm_flag_o, 8'h01);
        pm_u.wr(8'hDC, 8'h08);
        pm_u.ms(1, 1);
        chk("flag", zero_alarm_flag_o, 8'h00);
        $display("floor and saturation done");
        pm_u.wr(8'hDB, 8'h0F);
        pm_u.ms(1, 1);
        chk("flag", zero_alarm_flag_o, 8'h01);
        pm_u.wr(8'hDB, 8'h00);
        chk("irq", zero_irq_o, 8'h00);
        chk("flag", zero_alarm_flag_o, 8'h01);
        pm_u.wr(8'hDC, 8'h08);
        pm_u.ms(1, 1);
        chk("flag", zero_alarm_flag_o, 8'h00);
        chk("stat", stat_rdata_o, 8'h00);
        $display("weight edge cases done");
        wrap_up;
    end
endmodule // tb_zero_reading_detect_filter
`default_nettype wire
